/* hdl/dma_flags_pkg.sv */
// Shared constants and types for the channel flag and request routing block.
package dma_flags_pkg;

    // Channel and request dimensions.
    localparam int unsigned NUM_CH     = 3;
    localparam int unsigned FLAGS_PER  = 4;
    localparam int unsigned NUM_REQ    = 26;
    localparam int unsigned SEL_W      = 5;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned STAT_W     = NUM_CH * FLAGS_PER;

    // Register offsets (byte addresses).
    localparam logic [7:0] OFS_STATUS   = 8'h00;
    localparam logic [7:0] OFS_CLEAR    = 8'h04;
    localparam logic [7:0] OFS_CFG_BASE = 8'h08;
    localparam logic [7:0] OFS_CNT_BASE = 8'h20;
    localparam logic [7:0] OFS_SEL_BASE = 8'h40;
    localparam logic [7:0] OFS_MASK     = 8'h60;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h64;
    localparam logic [7:0] CH_STRIDE    = 8'h04;

    // Flag positions inside one channel's four-bit group.
    localparam int unsigned F_GLOBAL = 0;
    localparam int unsigned F_DONE   = 1;
    localparam int unsigned F_HALF   = 2;
    localparam int unsigned F_ERROR  = 3;

    // Channel configuration bit positions.
    localparam int unsigned C_EN    = 0;
    localparam int unsigned C_DONE  = 1;
    localparam int unsigned C_HALF  = 2;
    localparam int unsigned C_ERROR = 3;
    localparam int unsigned CFG_W   = 4;

    // Reset values.
    localparam logic [STAT_W-1:0] STAT_RST = 12'h000;
    localparam logic [CFG_W-1:0]  CFG_RST  = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
    localparam logic [SEL_W-1:0]  SEL_RST  = 5'h00;
    localparam logic [DATA_W-1:0] ZERO_W   = 32'h0000_0000;
    localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;

    // Events reported by one channel engine in one cycle.
    typedef struct packed {
        logic error;
        logic half;
        logic done;
    } ch_event_t;

    // Register bus request.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : dma_flags_pkg

/* hdl/dma_req_route.sv */
// Routes any peripheral request line to a channel by a select index.
`timescale 1ns/100ps
module dma_req_route #(
    parameter int unsigned N_REQ = 26,
    parameter int unsigned SW    = 5
) (
    input  wire logic [N_REQ-1:0] req_in,
    input  wire logic [SW-1:0]    sel,
    output logic                  req_out
);
    // Index past the last request reads as no request.
    always_comb begin
        req_out = 1'b0;
        if (32'(sel) < N_REQ) begin
            req_out = req_in[sel];
        end
    end
endmodule : dma_req_route

/* hdl/dma_ch_events.sv */
// One channel's count tracking and event detection.
`timescale 1ns/100ps
module dma_ch_events
    import dma_flags_pkg::*;
#(
    parameter int unsigned CW = 16
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          load,
    input  wire logic [CW-1:0] load_val,
    input  wire logic          beat_done,
    input  wire logic          beat_err,
    output logic [CW-1:0]      remain,
    output dma_flags_pkg::ch_event_t ev
);
    logic [CW-1:0] remain_q, remain_d;
    logic [CW-1:0] prog_q, prog_d;
    logic [CW-1:0] next_cnt;

    // Count down per beat, flag half and done crossings.
    always_comb begin
        remain_d = remain_q;
        prog_d   = prog_q;
        next_cnt = remain_q - CNT_ONE;
        ev       = '0;
        // A fault is never lost to a count write landing in the same cycle.
        ev.error = beat_err;
        if (load) begin
            remain_d = load_val;
            prog_d   = load_val;
        end else if (!beat_err && beat_done && remain_q != CNT_RST) begin
            remain_d = next_cnt;
            // Half point skipped when only one beat was programmed.
            ev.half  = (prog_q != CNT_ONE) && (next_cnt == (prog_q >> 1));
            ev.done  = (next_cnt == CNT_RST);
        end
    end

    // Registers.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            remain_q <= CNT_RST;
            prog_q   <= CNT_RST;
        end else begin
            remain_q <= remain_d;
            prog_q   <= prog_d;
        end
    end

    assign remain = remain_q;
endmodule : dma_ch_events

/* hdl/dma_error_interrupt_flags.sv */
// Flag status, clear, interrupt and request routing for three DMA channels.
//
// Operation
// - Access to reserved address space counts as a transfer error.
// - A transfer error clears the channel enable.
// - A transfer error sets the error flag; interrupt only if enabled.
// - Half, done and error each have a flag and own interrupt enable.
// - With count one, half never sets; done sets at completion.
// - Every peripheral request is selectable on each channel.
// - Flags set only by hardware; write one to clear register clears.
// - Global flag sets on any error, half or done event.
// - Done flag sets on completion and stays until cleared.
// - Channel 1 flags in bits 0..3: global, done, half, error.
// - Channel 2 flags in bits 4..7, same order.
// - Channel 3 flags in bits 8..11; upper bits reserved.
// - Global clear bit clears all four channel flags; zero writes ignored.
// - Clear register at offset 0x04, bits match status flags.
`timescale 1ns/100ps
module dma_error_interrupt_flags
    import dma_flags_pkg::*;
#(
    parameter int unsigned N_CH  = 3,
    parameter int unsigned N_REQ = 26
) (
    input  wire logic                               sys_clk,
    input  wire logic                               rst,
    input  wire logic [dma_flags_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [dma_flags_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic [dma_flags_pkg::DATA_W-1:0]        reg_rdata,
    input  wire logic [N_REQ-1:0]                   periph_req,
    input  wire logic [N_CH-1:0]                    beat_done,
    input  wire logic [N_CH-1:0]                    beat_reserved_addr,
    output logic [N_CH-1:0]                         ch_req,
    output logic [N_CH-1:0]                         ch_enable,
    output logic                                    irq
);
    import dma_flags_pkg::*;

    localparam int unsigned SW = N_CH * FLAGS_PER;

    // Synchronised peripheral requests.
    logic [N_REQ-1:0] req_s1_q, req_s2_q;

    // Register file and flags.
    logic [SW-1:0]     flags_q, flags_d;
    logic [SW-1:0]     mask_q, mask_d;
    logic [CFG_W-1:0]  cfg_q [N_CH];
    logic [CFG_W-1:0]  cfg_d [N_CH];
    logic [SEL_W-1:0]  sel_q [N_CH];
    logic [SEL_W-1:0]  sel_d [N_CH];
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [N_CH-1:0]   ch_req_q, ch_req_d;
    logic [N_CH-1:0]   en_q;
    logic              irq_q, irq_d;

    // Per-channel engine wiring.
    ch_event_t        ev [N_CH];
    logic [CNT_W-1:0] remain [N_CH];
    logic [N_CH-1:0]  load;
    logic [N_CH-1:0]  routed;
    logic [SW-1:0]    raw_irq;
    // Flag clear and set vectors of this cycle; the set vector is also watched by the assertions.
    logic [SW-1:0]    clr;
    logic [SW-1:0]    set;

    // Decode: true when address hits channel register n of a bank.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] base,
                                 input int unsigned n);
        return a == (base + 8'(n * CH_STRIDE));
    endfunction : hit

    // Two-flop synchroniser on the asynchronous request pins.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_s1_q <= '0;
            req_s2_q <= '0;
        end else begin
            req_s1_q <= periph_req;
            req_s2_q <= req_s1_q;
        end
    end

    // Per-channel count engine and request router.
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        assign load[c] = reg_wr && hit(reg_addr, OFS_CNT_BASE, c);

        dma_ch_events #(
            .CW (CNT_W)
        ) u_ev (
            .sys_clk   (sys_clk),
            .rst       (rst),
            .load      (load[c]),
            .load_val  (reg_wdata[CNT_W-1:0]),
            .beat_done (beat_done[c] && en_q[c]),
            .beat_err  (beat_reserved_addr[c] && en_q[c]),
            .remain    (remain[c]),
            .ev        (ev[c])
        );

        dma_req_route #(
            .N_REQ (N_REQ),
            .SW    (SEL_W)
        ) u_route (
            .req_in  (req_s2_q),
            .sel     (sel_q[c]),
            .req_out (routed[c])
        );

        assign en_q[c] = cfg_q[c][C_EN];
    end

    // Register writes, flag set and clear, channel enable.
    always_comb begin
        clr     = '0;
        set     = '0;
        mask_d  = mask_q;
        // Only the clear register clears flags; status writes fall through.
        if (reg_wr && reg_addr == OFS_CLEAR) begin
            clr = reg_wdata[SW-1:0];
        end
        if (reg_wr && reg_addr == OFS_MASK) begin
            mask_d = reg_wdata[SW-1:0];
        end
        for (int c = 0; c < N_CH; c++) begin
            cfg_d[c]      = cfg_q[c];
            sel_d[c]      = sel_q[c];
            if (reg_wr && hit(reg_addr, OFS_CFG_BASE, c)) begin
                cfg_d[c] = reg_wdata[CFG_W-1:0];
            end
            if (reg_wr && hit(reg_addr, OFS_SEL_BASE, c)) begin
                sel_d[c] = reg_wdata[SEL_W-1:0];
            end
            // Global clear takes the whole channel group.
            if (clr[c*FLAGS_PER+F_GLOBAL]) begin
                clr[c*FLAGS_PER +: FLAGS_PER] = '1;
            end
            set[c*FLAGS_PER+F_ERROR] = ev[c].error;
            set[c*FLAGS_PER+F_HALF]  = ev[c].half;
            set[c*FLAGS_PER+F_DONE]  = ev[c].done;
            set[c*FLAGS_PER+F_GLOBAL] = ev[c].error | ev[c].half | ev[c].done;
            // Error stops the channel, winning over a same-cycle enable write.
            if (ev[c].error) begin
                cfg_d[c][C_EN] = 1'b0;
            end
        end
        // Hardware set wins over a simultaneous clear.
        flags_d = (flags_q & ~clr) | set;
    end

    // Read data, routed requests and interrupt.
    always_comb begin
        raw_irq = '0;
        for (int c = 0; c < N_CH; c++) begin
            // Each event flag is gated by its own enable; the global flag raises none.
            raw_irq[c*FLAGS_PER+F_ERROR] = cfg_q[c][C_ERROR];
            raw_irq[c*FLAGS_PER+F_HALF]  = cfg_q[c][C_HALF];
            raw_irq[c*FLAGS_PER+F_DONE]  = cfg_q[c][C_DONE];
        end
        rdata_d = ZERO_W;
        if (reg_rd) begin
            if (reg_addr == OFS_STATUS) begin
                rdata_d[SW-1:0] = flags_q;
            end else if (reg_addr == OFS_MASK) begin
                rdata_d[SW-1:0] = mask_q;
            end else if (reg_addr == OFS_IRQ_STAT) begin
                rdata_d[SW-1:0] = flags_q & raw_irq;
            end
            for (int c = 0; c < N_CH; c++) begin
                if (hit(reg_addr, OFS_CFG_BASE, c)) begin
                    rdata_d[CFG_W-1:0] = cfg_q[c];
                end
                if (hit(reg_addr, OFS_CNT_BASE, c)) begin
                    rdata_d[CNT_W-1:0] = remain[c];
                end
                if (hit(reg_addr, OFS_SEL_BASE, c)) begin
                    rdata_d[SEL_W-1:0] = sel_q[c];
                end
            end
        end
        ch_req_d = routed & en_q;
        irq_d    = |(flags_q & raw_irq & ~mask_q);
    end

    // Registers.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q  <= STAT_RST;
            mask_q   <= '0;
            rdata_q  <= ZERO_W;
            ch_req_q <= '0;
            irq_q    <= 1'b0;
            for (int c = 0; c < N_CH; c++) begin
                cfg_q[c]      <= CFG_RST;
                sel_q[c]      <= SEL_RST;
            end
        end else begin
            flags_q  <= flags_d;
            mask_q   <= mask_d;
            rdata_q  <= rdata_d;
            ch_req_q <= ch_req_d;
            irq_q    <= irq_d;
            for (int c = 0; c < N_CH; c++) begin
                cfg_q[c]      <= cfg_d[c];
                sel_q[c]      <= sel_d[c];
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign ch_req    = ch_req_q;
    assign ch_enable = en_q;
    assign irq       = irq_q;

    // Error on an enabled channel sets its error and global flags next cycle.
    a_err_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ev[0].error |=> flags_q[F_ERROR] && flags_q[F_GLOBAL])
        else $error("error flag not set");

    // Error stops the channel next cycle.
    a_err_disables: assert property (@(posedge sys_clk) disable iff (rst)
        ev[1].error |=> !ch_enable[1])
        else $error("channel not disabled");

    // Global clear without event empties the group.
    a_global_clear: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_CLEAR && reg_wdata[F_GLOBAL] && !ev[0].error
        && !ev[0].half && !ev[0].done |=> flags_q[FLAGS_PER-1:0] == '0)
        else $error("global clear failed");

    // Set wins over clear.
    a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
        ev[2].done |=> flags_q[2*FLAGS_PER+F_DONE])
        else $error("done flag lost");

    // Status writes never change flags.
    a_status_ro: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_STATUS && set == '0 |=> $stable(flags_q))
        else $error("status write changed flags");

    // Global flag is set whenever another channel flag is.
    a_global_any: assert property (@(posedge sys_clk) disable iff (rst)
        flags_q[F_DONE] || flags_q[F_HALF] || flags_q[F_ERROR] |-> flags_q[F_GLOBAL])
        else $error("global flag missing");

    // Done flag holds until cleared.
    a_done_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        flags_q[F_DONE] && !(reg_wr && reg_addr == OFS_CLEAR) |=> flags_q[F_DONE])
        else $error("done flag dropped");

    // Status read returns flags one cycle later.
    a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == OFS_STATUS |=> reg_rdata == {20'h0_0000, $past(flags_q)})
        else $error("status read mismatch");

    // Interrupt follows an unmasked, enabled done flag by one cycle.
    a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
        flags_q[F_DONE] && cfg_q[0][C_DONE] && !mask_q[F_DONE] |=> irq)
        else $error("interrupt gating wrong");

    // Half event sets the half and global flags next cycle.
    a_half_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ev[0].half |=> flags_q[F_HALF] && flags_q[F_GLOBAL])
        else $error("half flag not set");

    // Done event on channel 2 sets its done and global flags.
    a_done_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
        ev[1].done |=> flags_q[FLAGS_PER+F_DONE] && flags_q[FLAGS_PER+F_GLOBAL])
        else $error("done flag not set");

    // Writing one to a done clear bit drops that flag when no event competes.
    a_clear_done: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_CLEAR && reg_wdata[F_DONE] && !ev[0].done
        |=> !flags_q[F_DONE])
        else $error("done flag not cleared");

    // A clear write of all zeros lets no flag fall.
    a_zero_clear_nop: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == OFS_CLEAR && reg_wdata == ZERO_W
        |=> ($past(flags_q) & ~flags_q) == '0)
        else $error("zero clear changed flags");

    // Unmasked enabled error flag on channel 3 raises the interrupt.
    a_irq_err_on: assert property (@(posedge sys_clk) disable iff (rst)
        flags_q[2*FLAGS_PER+F_ERROR] && cfg_q[2][C_ERROR] && !mask_q[2*FLAGS_PER+F_ERROR]
        |=> irq)
        else $error("error interrupt missing");

    // With no unmasked flag the interrupt falls.
    a_irq_quiet: assert property (@(posedge sys_clk) disable iff (rst)
        (flags_q & ~mask_q) == '0 |=> !irq)
        else $error("interrupt without flag");

    // A disabled channel forwards no request.
    a_req_gated: assert property (@(posedge sys_clk) disable iff (rst)
        !ch_enable[0] |=> !ch_req[0])
        else $error("request passed while disabled");

    // Reserved-space fault on an enabled channel is an error event.
    a_reserved_err: assert property (@(posedge sys_clk) disable iff (rst)
        beat_reserved_addr[0] && ch_enable[0] |-> ev[0].error)
        else $error("fault not reported");

    // Error on channel 3 stops it next cycle.
    a_err_ch2_off: assert property (@(posedge sys_clk) disable iff (rst)
        ev[2].error |=> !ch_enable[2])
        else $error("channel 3 not disabled");
endmodule : dma_error_interrupt_flags

/* sim/dma_periph_model.sv */
// Peripheral and bus slave model that issues beats, reserved-space faults and request levels.
`timescale 1ns/100ps
module dma_periph_model #(
    parameter int unsigned N_CH  = 3,
    parameter int unsigned N_REQ = 26
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             slow,
    input  wire logic [N_CH-1:0]  beat_go,
    input  wire logic [N_CH-1:0]  err_go,
    input  wire logic [N_REQ-1:0] req_pat,
    output logic      [N_CH-1:0]  beat_done,
    output logic      [N_CH-1:0]  beat_reserved_addr,
    output logic      [N_REQ-1:0] periph_req
);
    logic [N_CH-1:0] done_s1_q;
    logic [N_CH-1:0] done_s2_q;
    logic [N_CH-1:0] err_s1_q;
    logic [N_CH-1:0] err_s2_q;

    // Each command becomes a one-cycle pulse, one cycle later when answering slowly.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_s1_q  <= '0;
            done_s2_q  <= '0;
            err_s1_q   <= '0;
            err_s2_q   <= '0;
            periph_req <= '0;
        end else begin
            done_s1_q  <= beat_go;
            done_s2_q  <= done_s1_q;
            err_s1_q   <= err_go;
            err_s2_q   <= err_s1_q;
            periph_req <= req_pat;
        end
    end

    // The slow path delays the pulse but never stretches it.
    assign beat_done          = slow ? done_s2_q : done_s1_q;
    assign beat_reserved_addr = slow ? err_s2_q : err_s1_q;
endmodule : dma_periph_model

/* sim/dma_error_interrupt_flags_tb.sv */
// Self-checking bench for the channel flag, interrupt and request routing block.
`timescale 1ns/100ps
module dma_error_interrupt_flags_tb
    import dma_flags_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [25:0] periph_req;
    logic [25:0] req_pat = 26'h000_0000;
    logic [2:0]  beat_done;
    logic [2:0]  beat_reserved_addr;
    logic [2:0]  beat_go = 3'h0;
    logic [2:0]  err_go = 3'h0;
    logic        slow = 1'b0;
    logic [2:0]  ch_req;
    logic [2:0]  ch_enable;
    logic        irq;
    logic        rd_d = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0]  cfg_a;
    logic [7:0]  cnt_a;
    logic [31:0] pat;
    integer      seed = 85;
    int          err_count = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          sh;

    // The clock runs at 40 MHz.
    always #12.5 sys_clk = ~sys_clk;

    dma_error_interrupt_flags dma_error_interrupt_flags_i (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
        .beat_done(beat_done), .beat_reserved_addr(beat_reserved_addr), .ch_req(ch_req),
        .ch_enable(ch_enable), .irq(irq));

    dma_periph_model dma_periph_model_i (
        .sys_clk(sys_clk), .rst(rst), .slow(slow), .beat_go(beat_go), .err_go(err_go),
        .req_pat(req_pat), .beat_done(beat_done), .beat_reserved_addr(beat_reserved_addr),
        .periph_req(periph_req));

    // Prints the verdict and ends the run.
    task automatic summarize;
        if (err_count == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    // Compares one value and counts the result.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Waits n edges and ends mid-cycle, where the outputs have settled.
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : idle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Issues a read and notes the expected word for the watcher.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
    endtask : rd

    task automatic pulse(input int c, input int n, input logic err);
        repeat (n) begin
            @(posedge sys_clk);
            if (err) err_go <= 3'b001 << c;
            else beat_go <= 3'b001 << c;
            @(posedge sys_clk);
            err_go  <= 3'h0;
            beat_go <= 3'h0;
        end
        idle(5);
    endtask : pulse

    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge sys_clk) rd_d <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) check("rdata", reg_rdata, exp_q.pop_front());
    end

    // Cuts a hung run short.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(OFS_STATUS, ZERO_W);
        rd(8'h7C, ZERO_W);
        wr(OFS_STATUS, 32'h0000_0FFF);
        rd(OFS_STATUS, ZERO_W);
        for (int c = 0; c < 3; c++) begin
            sh    = 4 * c;
            slow  <= c[0];
            cfg_a = OFS_CFG_BASE + CH_STRIDE * 8'(c);
            cnt_a = OFS_CNT_BASE + CH_STRIDE * 8'(c);
            // Single-beat transfer: complete without half.
            wr(cfg_a, 32'h0000_000F);
            wr(cnt_a, 32'h0000_0001);
            pulse(c, 1, 1'b0);
            rd(OFS_STATUS, 32'h0000_0003 << sh);
            check("irq_done", 32'(irq), 32'h0000_0001);
            wr(OFS_MASK, 32'h0000_0002 << sh);
            rd(OFS_MASK, 32'h0000_0002 << sh);
            idle(3);
            check("irq_masked", 32'(irq), ZERO_W);
            wr(OFS_MASK, ZERO_W);
            wr(OFS_CLEAR, 32'h0000_0002 << sh);
            rd(OFS_STATUS, 32'h0000_0001 << sh);
            wr(OFS_CLEAR, ZERO_W);
            rd(OFS_STATUS, 32'h0000_0001 << sh);
            wr(OFS_CLEAR, 32'h0000_0001 << sh);
            rd(OFS_STATUS, ZERO_W);
            // Four beats: half at two, complete at four.
            wr(cnt_a, 32'h0000_0004);
            pulse(c, 2, 1'b0);
            rd(OFS_STATUS, 32'h0000_0005 << sh);
            check("irq_half", 32'(irq), 32'h0000_0001);
            rd(OFS_IRQ_STAT, 32'h0000_0004 << sh);
            rd(cnt_a, 32'h0000_0002);
            pulse(c, 2, 1'b0);
            idle(4);
            rd(OFS_STATUS, 32'h0000_0007 << sh);
            wr(OFS_CLEAR, 32'h0000_0FFF);
            idle(3);
            check("irq_clear", 32'(irq), ZERO_W);
            // Reserved-space fault with its interrupt disabled, then enabled.
            wr(cfg_a, 32'h0000_0001);
            pulse(c, 1, 1'b1);
            check("enable", 32'(ch_enable), ZERO_W);
            rd(OFS_STATUS, 32'h0000_0009 << sh);
            check("irq_err_off", 32'(irq), ZERO_W);
            rd(cfg_a, ZERO_W);
            wr(OFS_CLEAR, 32'h0000_0001 << sh);
            rd(OFS_STATUS, ZERO_W);
            wr(cfg_a, 32'h0000_0009);
            pulse(c, 1, 1'b1);
            rd(OFS_STATUS, 32'h0000_0009 << sh);
            check("irq_err_on", 32'(irq), 32'h0000_0001);
            wr(OFS_CLEAR, 32'h0000_0001 << sh);
            idle(3);
            check("irq_err_clr", 32'(irq), ZERO_W);
        end
        // Every request index on every channel, and one index past the last.
        for (int c = 0; c < 3; c++) begin
            wr(OFS_CFG_BASE + CH_STRIDE * 8'(c), 32'h0000_0001);
            for (int s = 0; s <= 26; s++) begin
                wr(OFS_SEL_BASE + CH_STRIDE * 8'(c), 32'(s));
                pat = $random(seed);
                req_pat <= pat[25:0];
                idle(6);
                check("ch_req", 32'(ch_req), (s < 26) ? 32'(pat[s]) << c : ZERO_W);
            end
            wr(OFS_CFG_BASE + CH_STRIDE * 8'(c), ZERO_W);
        end
        idle(4);
        summarize();
    end
endmodule : dma_error_interrupt_flags_tb
